/* design/cid_pkg.sv */
// Constants, opcodes and types for the instruction decoder tail
package cid_pkg;
    localparam logic [7:0] OP_PREFIX = 8'h9E;
    localparam logic [7:0] OP_HALT = 8'h8E;
    localparam logic [7:0] OP_TRAP = 8'h83;
    localparam logic [7:0] OP_TEST_A = 8'h4D;
    localparam logic [7:0] OP_TEST_X = 8'h5D;
    localparam logic [7:0] OP_SP_TO_IX = 8'h95;
    localparam logic [7:0] OP_IX_TO_SP = 8'h94;
    localparam logic [7:0] OP_A_TO_FL = 8'h84;
    localparam logic [7:0] OP_FL_TO_A = 8'h85;
    localparam logic [7:0] OP_A_TO_X = 8'h97;
    localparam logic [7:0] OP_X_TO_A = 8'h9F;
    localparam logic [7:0] OP_MOV_LIT = 8'h6E;
    localparam logic [7:0] OP_MOV_IXPD = 8'h7E;
    localparam logic [7:0] OP_CBEQ_IX1P = 8'h61;
    localparam logic [7:0] OP_CBEQ_IXP = 8'h71;
    localparam logic [7:0] OP_BRA = 8'h20;
    localparam logic [3:0] LO_SUB = 4'h0;
    localparam logic [3:0] LO_TEST = 4'hD;
    localparam logic [3:0] LO_STORE_X = 4'hF;
    // Flags layout: V 1 1 H I N Z C
    localparam int FL_V = 7;
    localparam int FL_I = 3;
    localparam int FL_N = 2;
    localparam int FL_Z = 1;
    localparam int FL_C = 0;
    localparam logic [7:0] FL_FIXED = 8'h60;
    localparam logic [7:0] FL_RST = 8'h68;
    localparam logic [15:0] SP_RST = 16'h00FF;
    localparam logic [15:0] VEC_ADDR = 16'hFFFC;
    // Register map, byte addresses
    localparam logic [7:0] RA_CTRL = 8'h00;
    localparam logic [7:0] RA_STATUS = 8'h04;
    localparam logic [7:0] RA_ACC = 8'h08;
    localparam logic [7:0] RA_INDEX = 8'h0C;
    localparam logic [7:0] RA_SP = 8'h10;
    localparam logic [7:0] RA_PC = 8'h14;
    localparam int CTRL_RUN = 0;
    localparam int CTRL_WAKE = 1;
    localparam int STAT_STOPPED = 0;
    localparam int STAT_TRAP = 1;
    localparam logic [3:0] CYC_DEFAULT = 4'h1;

    typedef enum logic [3:0] {
        ST_FETCH = 4'h0, ST_DEC = 4'h1, ST_OPA = 4'h3, ST_OPB = 4'h2,
        ST_ACC = 4'h6, ST_MRD = 4'h7, ST_PAD = 4'h5, ST_PUSH = 4'h4,
        ST_VEC = 4'hC, ST_STOP = 4'hD
    } cid_state_t;

    typedef enum logic [3:0] {
        M_INH, M_IMM, M_DIR, M_FULL, M_IDX16, M_IDX8, M_IX, M_STK8, M_STK16,
        M_IXP, M_IX1P, M_LIT, M_IXPD, M_REL
    } cid_mode_t;
endpackage : cid_pkg

/* design/cid_core.sv */
// CPU decode and execute core with Avalon-MM control registers
//
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module cid_core
    import cid_pkg::*;
#(
    parameter logic [15:0] RESET_PC = 16'h0000
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [15:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    output logic stop_osc,
    output logic irq_mask
);

    function automatic cid_mode_t mode_of(input logic pfx, input logic [7:0] op);
        cid_mode_t m;
        m = M_INH;
        if (pfx) begin
            m = (op[7:4] == 4'hD) ? M_STK16 : M_STK8;
        end else if (op == OP_MOV_LIT) begin
            m = M_LIT;
        end else if (op == OP_MOV_IXPD) begin
            m = M_IXPD;
        end else if (op == OP_CBEQ_IX1P) begin
            m = M_IX1P;
        end else if (op == OP_CBEQ_IXP) begin
            m = M_IXP;
        end else if (op == OP_BRA) begin
            m = M_REL;
        end else begin
            case (op[7:4])
                4'h3, 4'hB: m = M_DIR;
                4'h6, 4'hE: m = M_IDX8;
                4'h7, 4'hF: m = M_IX;
                4'hA: m = M_IMM;
                4'hC: m = M_FULL;
                4'hD: m = M_IDX16;
                default: m = M_INH;
            endcase
        end
        return m;
    endfunction : mode_of

    function automatic logic [1:0] nops_of(input cid_mode_t m);
        case (m)
            M_FULL, M_IDX16, M_STK16, M_IX1P, M_LIT: return 2'd2;
            M_INH, M_IX: return 2'd0;
            default: return 2'd1;
        endcase
    endfunction : nops_of

    function automatic logic [3:0] cyc_of(input logic pfx, input logic [7:0] op);
        logic [3:0] c;
        c = CYC_DEFAULT;
        if (pfx) begin
            c = (op[7:4] == 4'hD) ? 4'd5 : 4'd4;
        end else begin
            case (op)
                OP_HALT, OP_TEST_A, OP_TEST_X, OP_FL_TO_A, OP_A_TO_X, OP_X_TO_A: c = 4'd1;
                OP_TRAP: c = 4'd9;
                OP_SP_TO_IX, OP_IX_TO_SP, OP_A_TO_FL: c = 4'd2;
                OP_MOV_LIT, OP_MOV_IXPD, OP_CBEQ_IXP: c = 4'd4;
                OP_CBEQ_IX1P: c = 4'd5;
                OP_BRA: c = 4'd3;
                8'h3D, 8'h6D, 8'hBF, 8'hEF, 8'hB0, 8'hE0: c = 4'd3;
                8'h7D, 8'hFF, 8'hA0, 8'hF0: c = 4'd2;
                8'hCF, 8'hDF, 8'hC0, 8'hD0: c = 4'd4;
                default: c = CYC_DEFAULT;
            endcase
        end
        return c;
    endfunction : cyc_of

    function automatic logic [15:0] ea_of(input cid_mode_t m, input logic [7:0] b1,
                                           input logic [7:0] b2, input logic [15:0] hx,
                                           input logic [15:0] sp);
        case (m)
            M_DIR, M_IXPD: return {8'h00, b1};
            M_FULL: return {b1, b2};
            M_IDX16: return hx + {b1, b2};
            M_IDX8, M_IX1P: return hx + {8'h00, b1};
            M_STK8: return sp + {8'h00, b1};
            M_STK16: return sp + {b1, b2};
            M_LIT: return {8'h00, b2};
            default: return hx;
        endcase
    endfunction : ea_of

    function automatic logic [7:0] nz_flags(input logic [7:0] f, input logic [7:0] v);
        logic [7:0] r;
        r = f;
        r[FL_V] = 1'b0;
        r[FL_N] = v[7];
        r[FL_Z] = (v == 8'h00);
        return r;
    endfunction : nz_flags

    cid_state_t state_reg;
    cid_mode_t mode_reg;
    logic pfx_reg;
    logic [7:0] op_reg;
    logic [7:0] b1_reg;
    logic [7:0] b2_reg;
    logic [15:0] ea_reg;
    logic [15:0] pc_reg;
    logic [15:0] sp_reg;
    logic [15:0] hx_reg;
    logic [7:0] acc_reg;
    logic [7:0] flags_reg;
    logic [3:0] lim_reg;
    logic [3:0] cnt_reg;
    logic [2:0] idx_reg;
    logic trap_seen_reg;
    logic run_reg;
    logic bus_ack;
    logic wake_pulse;
    logic trap_clear;
    cid_mode_t dec_mode;
    logic [7:0] opnd;
    logic [7:0] diff;
    logic [7:0] rel_byte;

    assign dec_mode = mode_of(pfx_reg, mem_rdata);
    assign opnd = (mode_reg == M_IMM) ? b1_reg : mem_rdata;
    assign diff = acc_reg - opnd;
    assign rel_byte = (mode_reg == M_IXP) ? b1_reg : b2_reg;
    assign bus_ack = !avs_waitrequest && (avs_read || avs_write);
    assign wake_pulse = bus_ack && avs_write && (avs_address == RA_CTRL)
                        && avs_writedata[CTRL_WAKE];
    assign trap_clear = bus_ack && avs_write && (avs_address == RA_STATUS)
                        && avs_writedata[STAT_TRAP];

    // Instruction sequencer and datapath
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_reg <= ST_FETCH;
            mode_reg <= M_INH;
            pfx_reg <= 1'b0;
            op_reg <= 8'h00;
            b1_reg <= 8'h00;
            b2_reg <= 8'h00;
            ea_reg <= 16'h0000;
            pc_reg <= RESET_PC;
            sp_reg <= SP_RST;
            hx_reg <= 16'h0000;
            acc_reg <= 8'h00;
            flags_reg <= FL_RST;
            lim_reg <= CYC_DEFAULT;
            cnt_reg <= 4'h0;
            idx_reg <= 3'd0;
            mem_addr <= 16'h0000;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_wdata <= 8'h00;
            stop_osc <= 1'b0;
        end else begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            if (cnt_reg != 4'hF) begin
                cnt_reg <= cnt_reg + 4'd1;
            end
            case (state_reg)
                ST_FETCH: begin
                    if (run_reg) begin
                        mem_rd <= 1'b1;
                        mem_addr <= pc_reg;
                        pc_reg <= pc_reg + 16'd1;
                        pfx_reg <= 1'b0;
                        cnt_reg <= 4'd1;
                        state_reg <= ST_DEC;
                    end
                end
                ST_DEC: begin
                    op_reg <= mem_rdata;
                    mode_reg <= dec_mode;
                    lim_reg <= cyc_of(pfx_reg, mem_rdata);
                    if (mem_rdata == OP_PREFIX && !pfx_reg) begin
                        pfx_reg <= 1'b1;
                        mem_rd <= 1'b1;
                        mem_addr <= pc_reg;
                        pc_reg <= pc_reg + 16'd1;
                    end else if (nops_of(dec_mode) != 2'd0) begin
                        mem_rd <= 1'b1;
                        mem_addr <= pc_reg;
                        pc_reg <= pc_reg + 16'd1;
                        state_reg <= ST_OPA;
                    end else if (dec_mode == M_IX) begin
                        ea_reg <= hx_reg;
                        state_reg <= ST_ACC;
                    end else begin
                        state_reg <= ST_PAD;
                        case (mem_rdata)
                            OP_HALT: begin
                                flags_reg[FL_I] <= 1'b0;
                                state_reg <= ST_STOP;
                            end
                            OP_TRAP: begin
                                idx_reg <= 3'd0;
                                state_reg <= ST_PUSH;
                            end
                            OP_TEST_A: flags_reg <= nz_flags(flags_reg, acc_reg);
                            OP_TEST_X: flags_reg <= nz_flags(flags_reg, hx_reg[7:0]);
                            OP_SP_TO_IX: hx_reg <= sp_reg + 16'd1;
                            OP_IX_TO_SP: sp_reg <= hx_reg - 16'd1;
                            OP_A_TO_FL: flags_reg <= acc_reg | FL_FIXED;
                            OP_FL_TO_A: acc_reg <= flags_reg;
                            OP_A_TO_X: hx_reg[7:0] <= acc_reg;
                            OP_X_TO_A: acc_reg <= hx_reg[7:0];
                            default: ;
                        endcase
                    end
                end
                ST_OPA: begin
                    b1_reg <= mem_rdata;
                    if (nops_of(mode_reg) == 2'd2) begin
                        mem_rd <= 1'b1;
                        mem_addr <= pc_reg;
                        pc_reg <= pc_reg + 16'd1;
                        state_reg <= ST_OPB;
                    end else if (mode_reg == M_REL) begin
                        pc_reg <= pc_reg + {{8{mem_rdata[7]}}, mem_rdata};
                        state_reg <= ST_PAD;
                    end else if (mode_reg == M_IMM) begin
                        state_reg <= ST_MRD;
                    end else begin
                        ea_reg <= ea_of(mode_reg, mem_rdata, b2_reg, hx_reg, sp_reg);
                        state_reg <= ST_ACC;
                    end
                end
                ST_OPB: begin
                    b2_reg <= mem_rdata;
                    ea_reg <= ea_of(mode_reg, b1_reg, mem_rdata, hx_reg, sp_reg);
                    state_reg <= ST_ACC;
                end
                ST_ACC: begin
                    state_reg <= ST_PAD;
                    if (mode_reg == M_LIT) begin
                        mem_wr <= 1'b1;
                        mem_addr <= ea_reg;
                        mem_wdata <= b1_reg;
                        flags_reg <= nz_flags(flags_reg, b1_reg);
                    end else if (mode_reg == M_IXPD) begin
                        mem_rd <= 1'b1;
                        mem_addr <= hx_reg;
                        state_reg <= ST_MRD;
                    end else if (op_reg[3:0] == LO_STORE_X) begin
                        mem_wr <= 1'b1;
                        mem_addr <= ea_reg;
                        mem_wdata <= hx_reg[7:0];
                        flags_reg <= nz_flags(flags_reg, hx_reg[7:0]);
                    end else begin
                        mem_rd <= 1'b1;
                        mem_addr <= (mode_reg == M_IX1P) ? ea_reg : ea_reg;
                        state_reg <= ST_MRD;
                    end
                end
                ST_MRD: begin
                    state_reg <= ST_PAD;
                    if (mode_reg == M_IXPD) begin
                        mem_wr <= 1'b1;
                        mem_addr <= {8'h00, b1_reg};
                        mem_wdata <= opnd;
                        hx_reg <= hx_reg + 16'd1;
                        flags_reg <= nz_flags(flags_reg, opnd);
                    end else if (mode_reg == M_IXP || mode_reg == M_IX1P) begin
                        hx_reg <= hx_reg + 16'd1;
                        if (acc_reg == opnd) begin
                            pc_reg <= pc_reg + {{8{rel_byte[7]}}, rel_byte};
                        end
                    end else if (op_reg[3:0] == LO_SUB) begin
                        acc_reg <= diff;
                        flags_reg[FL_V] <= (acc_reg[7] & ~opnd[7] & ~diff[7])
                                         | (~acc_reg[7] & opnd[7] & diff[7]);
                        flags_reg[FL_N] <= diff[7];
                        flags_reg[FL_Z] <= (diff == 8'h00);
                        flags_reg[FL_C] <= (~acc_reg[7] & opnd[7]) | (opnd[7] & diff[7])
                                         | (diff[7] & ~acc_reg[7]);
                    end else if (op_reg[3:0] == LO_TEST) begin
                        flags_reg <= nz_flags(flags_reg, opnd);
                    end
                end
                ST_PUSH: begin
                    mem_wr <= 1'b1;
                    mem_addr <= sp_reg;
                    sp_reg <= sp_reg - 16'd1;
                    idx_reg <= idx_reg + 3'd1;
                    case (idx_reg)
                        3'd0: mem_wdata <= pc_reg[7:0];
                        3'd1: mem_wdata <= pc_reg[15:8];
                        3'd2: mem_wdata <= hx_reg[7:0];
                        3'd3: mem_wdata <= acc_reg;
                        default: mem_wdata <= flags_reg;
                    endcase
                    if (idx_reg == 3'd4) begin
                        flags_reg[FL_I] <= 1'b1;
                        idx_reg <= 3'd0;
                        state_reg <= ST_VEC;
                    end
                end
                ST_VEC: begin
                    idx_reg <= idx_reg + 3'd1;
                    if (idx_reg == 3'd0) begin
                        mem_rd <= 1'b1;
                        mem_addr <= VEC_ADDR;
                    end else if (idx_reg == 3'd1) begin
                        pc_reg[15:8] <= mem_rdata;
                        mem_rd <= 1'b1;
                        mem_addr <= VEC_ADDR + 16'd1;
                    end else begin
                        pc_reg[7:0] <= mem_rdata;
                        state_reg <= ST_PAD;
                    end
                end
                ST_PAD: begin
                    // Stretch each instruction to at least its listed cycle count
                    if ({1'b0, cnt_reg} + 5'd1 >= {1'b0, lim_reg}) begin
                        state_reg <= ST_FETCH;
                    end
                end
                ST_STOP: begin
                    stop_osc <= 1'b1;
                    if (wake_pulse) begin
                        stop_osc <= 1'b0;
                        state_reg <= ST_FETCH;
                    end
                end
                default: state_reg <= ST_FETCH;
            endcase
        end
    end

    // Mask bit mirrored to a pin
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq_mask <= 1'b1;
        end else begin
            irq_mask <= flags_reg[FL_I];
        end
    end

    // Sticky trap indicator: a new trap wins over a software clear
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            trap_seen_reg <= 1'b0;
        end else if (state_reg == ST_PUSH && idx_reg == 3'd4) begin
            trap_seen_reg <= 1'b1;
        end else if (trap_clear) begin
            trap_seen_reg <= 1'b0;
        end
    end

    // Avalon-MM slave: one wait cycle, then the access completes
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            run_reg <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
            if ((avs_read || avs_write) && avs_waitrequest) begin
                avs_waitrequest <= 1'b0;
                if (avs_address == RA_CTRL) begin
                    avs_readdata <= {31'h0000_0000, run_reg};
                end else if (avs_address == RA_STATUS) begin
                    avs_readdata <= {30'h0000_0000, trap_seen_reg, state_reg == ST_STOP};
                end else if (avs_address == RA_ACC) begin
                    avs_readdata <= {16'h0000, flags_reg | FL_FIXED, acc_reg};
                end else if (avs_address == RA_INDEX) begin
                    avs_readdata <= {16'h0000, hx_reg};
                end else if (avs_address == RA_SP) begin
                    avs_readdata <= {16'h0000, sp_reg};
                end else if (avs_address == RA_PC) begin
                    avs_readdata <= {16'h0000, pc_reg};
                end else begin
                    avs_readdata <= 32'h0000_0000;
                end
            end
            if (bus_ack && avs_write && avs_address == RA_CTRL) begin
                run_reg <= avs_writedata[CTRL_RUN];
            end
        end
    end

endmodule : cid_core
`default_nettype wire

/* dv/cid_mem_model.sv */
// Program and data memory model on the CPU bus
`timescale 1ns/100ps
`default_nettype none
module cid_mem_model (
    input wire logic ref_clk,
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] idle_reg = 8'h00;
    // Data stands only while the read strobe is high; otherwise the bus shows the inverse of its own value one cycle earlier
    assign mem_rdata = mem_rd ? mem[mem_addr] : idle_reg;
    always @(posedge ref_clk) begin
        idle_reg <= ~mem_rdata;
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
        end
    end
endmodule : cid_mem_model
`default_nettype wire

/* dv/cid_core_asserts.sv */
// Port checker for the decoder core
`timescale 1ns/100ps
`default_nettype none
module cid_core_asserts
    import cid_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic stop_osc,
    input wire logic irq_mask
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    property p_bus_answer;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus request not answered");
    property p_wait_pulse;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
    property p_mem_excl;
        !(mem_rd && mem_wr);
    endproperty
    a_mem_excl: assert property (p_mem_excl) else $error("memory read and write together");
    property p_halt_unmask;
        $rose(stop_osc) |-> ##[0:2] !irq_mask;
    endproperty
    a_halt_unmask: assert property (p_halt_unmask) else $error("halt left mask set");
    property p_halt_quiet;
        stop_osc && $past(stop_osc) |-> !mem_rd && !mem_wr;
    endproperty
    a_halt_quiet: assert property (p_halt_quiet) else $error("bus active while halted");
    property p_push_down;
        mem_wr && $past(mem_wr) |-> mem_addr == $past(mem_addr) - 16'h0001;
    endproperty
    a_push_down: assert property (p_push_down) else $error("push address not descending");
    property p_vec_order;
        mem_rd && mem_addr == VEC_ADDR |-> ##[1:2] mem_rd && mem_addr == VEC_ADDR + 16'h0001;
    endproperty
    a_vec_order: assert property (p_vec_order) else $error("vector low byte not read");
    property p_vec_mask;
        mem_rd && mem_addr == VEC_ADDR + 16'h0001 |-> ##[0:2] irq_mask;
    endproperty
    a_vec_mask: assert property (p_vec_mask) else $error("trap did not set mask");
    c_push: cover property (mem_wr && $past(mem_wr));
    c_halt: cover property ($rose(stop_osc));
    c_bus: cover property (avs_read && !avs_waitrequest);
endmodule : cid_core_asserts
`default_nettype wire

/* dv/cid_core_tb_top.sv */
// Self-checking testbench for the decoder core
`timescale 1ns/100ps
`default_nettype none
module cid_core_tb_top;
    import cid_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, mem_rd, mem_wr, stop_osc, irq_mask;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata, mem_rdata;
    logic [7:0] prog [0:11];
    logic [7:0] push_exp [0:4];
    logic [7:0] prog2 [0:32];
    logic [15:0] st_addr [0:6];
    logic [7:0] st_val [0:6];
    int num_errors = 0;
    int checks_done = 0;
    int k;
    always #2.5 ref_clk = ~ref_clk;
    cid_core u_dut (.ref_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .mem_addr, .mem_rd, .mem_wr, .mem_wdata,
        .mem_rdata, .stop_osc, .irq_mask);
    cid_mem_model u_mem (.ref_clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp32
    task automatic bus_wr(input logic [7:0] addr, input logic [31:0] data);
        @(posedge ref_clk);
        avs_address <= addr;
        avs_writedata <= data;
        avs_write <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask : bus_wr
    task automatic chk_reg(input logic [7:0] addr, input logic [31:0] exp);
        @(posedge ref_clk);
        avs_address <= addr;
        avs_read <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        cmp32(avs_readdata, exp);
        avs_read <= 1'b0;
    endtask : chk_reg
    initial begin
        #20000;
        num_errors++;
        $display("Error at %0t: watchdog expired", $time);
        print_verdict();
    end
    initial begin
        // Sub, copy to index, store full address, sp/index moves, move literal, trap
        prog = '{8'hA0, 8'h01, 8'h97, 8'hCF, 8'h12, 8'h34, 8'h95, 8'h94,
                 8'h6E, 8'h5A, 8'h40, 8'h83};
        push_exp = '{8'h0C, 8'h00, 8'h00, 8'hFF, 8'h69};
        // After wake: tests, stores in each indexed and stack form, moves, compares, trap
        prog2 = '{8'h4D, 8'h3D, 8'h40, 8'h95, 8'h9E, 8'h6D, 8'h02, 8'hEF, 8'h10, 8'hDF, 8'h01,
                  8'h00, 8'h9E, 8'hEF, 8'h06, 8'h9E, 8'hDF, 8'h02, 8'h00, 8'hFF, 8'h7E, 8'h50,
                  8'h71, 8'h01, 8'h97, 8'h61, 8'h02, 8'h01, 8'h85, 8'h20, 8'h01, 8'h97, 8'h83};
        st_addr = '{16'h010B, 16'h01FB, 16'h0100, 16'h02FA, 16'h0050, 16'h00FA, 16'h00F6};
        st_val = '{8'hFB, 8'hFB, 8'hFB, 8'hFB, 8'hFB, 8'h22, 8'h65};
        for (k = 0; k < 65536; k++) u_mem.mem[k] = 8'h9D;
        for (k = 0; k < 12; k++) u_mem.mem[k] = prog[k];
        u_mem.mem[16'hFFFC] = 8'h02;
        u_mem.mem[16'hFFFD] = 8'h00;
        // Handler: halt; after wake run the second program, which traps back here
        u_mem.mem[16'h0200] = 8'h8E;
        for (k = 0; k < 33; k++) u_mem.mem[16'h0201 + k] = prog2[k];
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        chk_reg(RA_CTRL, 32'h0);
        chk_reg(RA_SP, 32'h0000_00FF);
        bus_wr(RA_CTRL, 32'h1);
        for (k = 0; k < 300 && stop_osc !== 1'b1; k++) @(posedge ref_clk);
        repeat (3) @(posedge ref_clk);
        cmp32({31'h0, stop_osc}, 32'h1);
        cmp32({31'h0, irq_mask}, 32'h0);
        chk_reg(RA_STATUS, 32'h3);
        chk_reg(RA_ACC, 32'h0000_61FF);
        chk_reg(RA_INDEX, 32'h0000_0100);
        chk_reg(RA_SP, 32'h0000_00FA);
        chk_reg(8'h20, 32'h0);
        cmp32({24'h0, u_mem.mem[16'h1234]}, 32'hFF);
        cmp32({24'h0, u_mem.mem[16'h0040]}, 32'h5A);
        for (k = 0; k < 5; k++) cmp32({24'h0, u_mem.mem[8'hFF - k]}, {24'h0, push_exp[k]});
        bus_wr(RA_STATUS, 32'h2);
        chk_reg(RA_STATUS, 32'h1);
        bus_wr(RA_CTRL, 32'h3);
        @(posedge ref_clk);
        cmp32({31'h0, stop_osc}, 32'h0);
        for (k = 0; k < 400 && stop_osc !== 1'b1; k++) @(posedge ref_clk);
        repeat (3) @(posedge ref_clk);
        cmp32({30'h0, stop_osc, irq_mask}, 32'h2);
        chk_reg(RA_STATUS, 32'h3);
        chk_reg(RA_ACC, 32'h0000_6565);
        chk_reg(RA_INDEX, 32'h0000_00FE);
        chk_reg(RA_SP, 32'h0000_00F5);
        for (k = 0; k < 7; k++) begin
            cmp32({24'h0, u_mem.mem[st_addr[k]]}, {24'h0, st_val[k]});
        end
        print_verdict();
    end
endmodule : cid_core_tb_top
bind cid_core cid_core_asserts u_chk (.ref_clk, .srst, .avs_read, .avs_write, .avs_waitrequest,
    .mem_addr, .mem_rd, .mem_wr, .stop_osc, .irq_mask);
`default_nettype wire
